//--- sbsp_top.sv
// smbus register target with the shared open-drain lock / carrier / interrupt pin
// assumes all pin inputs are asynchronous and bus clock is well below the system clock
`timescale 1ns/1ns
module sbsp_top
  import sbsp_pkg::*;
(
  input  wire logic                       CLK_I,
  input  wire logic                       RST_N_I,
  input  wire logic                       SCL_I,
  output logic                            SCL_O,
  output logic                            SCL_OE_N_O,
  input  wire logic                       SDA_I,
  output logic                            SDA_O,
  output logic                            SDA_OE_N_O,
  input  wire logic [1:0]                 MODE_SELECT_I,
  input  wire logic [1:0]                 ADDRESS_STRAP_MAJOR_I,
  input  wire logic [1:0]                 ADDRESS_STRAP_MINOR_I,
  input  wire logic                       RECLOCK_LOCK_I,
  input  wire logic                       BIDIR_COAX_PORT_CD_I,
  input  wire logic                       HOST_DIFF_INPUT_CD_I,
  input  wire logic                       ADAPT_DONE_I,
  input  wire logic                       CABLE_DRIVER_MODE_I,
  input  wire logic                       HORIZONTAL_EYE_OPENING_LOW_I,
  input  wire logic                       VERTICAL_EYE_OPENING_LOW_I,
  input  wire logic [sbsp_pkg::IDX_W-1:0] CABLE_EQ_BOOST_INDEX_I,
  output logic      [sbsp_pkg::IDX_W-1:0] MUTE_THRESHOLD_O,
  output logic                            SMBUS_SELECTED_O,
  output logic                            STATUS_PIN_O,
  output logic                            STATUS_PIN_OE_N_O
);
  import sbsp_pkg::*;

  localparam int SW = 21;

  logic [SW-1:0]    sync_raw;
  logic [SW-1:0]    sync_out;
  logic             scl_s;
  logic             sda_s;
  logic             lock_s;
  logic             coax_cd_s;
  logic             host_cd_s;
  logic             adapt_s;
  logic             cd_mode_s;
  logic             heo_s;
  logic             veo_s;
  logic [1:0]       maj_s;
  logic [1:0]       min_s;
  logic [1:0]       mode_s;
  logic [IDX_W-1:0] boost_s;

  // every pin passes two flops; the 125 MHz sampling resolves a 400 kHz bus clock
  assign sync_raw = {SCL_I, SDA_I, RECLOCK_LOCK_I, BIDIR_COAX_PORT_CD_I, HOST_DIFF_INPUT_CD_I,
                     ADAPT_DONE_I, CABLE_DRIVER_MODE_I, HORIZONTAL_EYE_OPENING_LOW_I,
                     VERTICAL_EYE_OPENING_LOW_I, ADDRESS_STRAP_MAJOR_I, ADDRESS_STRAP_MINOR_I,
                     MODE_SELECT_I, CABLE_EQ_BOOST_INDEX_I};

  sbsp_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (sync_raw),
    .q_o     (sync_out)
  );

  assign {scl_s, sda_s, lock_s, coax_cd_s, host_cd_s, adapt_s, cd_mode_s, heo_s, veo_s,
          maj_s, min_s, mode_s, boost_s} = sync_out;

  // strap capture, once after reset release
  logic [1:0] strap_cnt_reg;
  logic [1:0] strap_cnt_next;
  logic       strap_done_reg;
  logic       strap_done_next;
  logic [6:0] target_addr_reg;
  logic [6:0] target_addr_next;
  logic       smbus_en_reg;
  logic       smbus_en_next;

  always_comb begin
    strap_cnt_next   = strap_cnt_reg;
    strap_done_next  = strap_done_reg;
    target_addr_next = target_addr_reg;
    smbus_en_next    = smbus_en_reg;
    if (!strap_done_reg) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == STRAP_SETTLE_CYC) begin
        strap_done_next  = 1'b1;
        target_addr_next = TARGET_ADDR_BASE + {3'b000, maj_s, min_s};
        smbus_en_next    = (mode_s == LVL_L);
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      strap_cnt_reg   <= 2'h0;
      strap_done_reg  <= 1'b0;
      target_addr_reg <= 7'h00;
      smbus_en_reg    <= 1'b0;
    end else begin
      strap_cnt_reg   <= strap_cnt_next;
      strap_done_reg  <= strap_done_next;
      target_addr_reg <= target_addr_next;
      smbus_en_reg    <= smbus_en_next;
    end
  end

  // bus line history and conditions
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_d_reg <= 1'b0;
      sda_d_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = smbus_en_reg & scl_s & ~scl_d_reg;
  assign scl_fall  = smbus_en_reg & ~scl_s & scl_d_reg;
  assign bus_start = smbus_en_reg & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = smbus_en_reg & scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // smbus target state machine
  sbsp_state_e state_reg;
  sbsp_state_e state_next;
  logic [3:0]  bitcnt_reg;
  logic [3:0]  bitcnt_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [7:0]  regptr_reg;
  logic [7:0]  regptr_next;
  logic        rw_reg;
  logic        rw_next;
  logic        sda_low_reg;
  logic        sda_low_next;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rdata;

  always_comb begin
    state_next   = state_reg;
    bitcnt_next  = bitcnt_reg;
    shift_next   = shift_reg;
    regptr_next  = regptr_reg;
    rw_next      = rw_reg;
    sda_low_next = sda_low_reg;
    wr_stb       = 1'b0;
    rd_stb       = 1'b0;
    if (bus_stop) begin
      state_next   = ST_IDLE;
      sda_low_next = 1'b0;
    end else if (bus_start) begin
      state_next   = ST_ADDR;
      bitcnt_next  = 4'h0;
      sda_low_next = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_REGA, ST_WDAT: begin
          if (scl_rise) begin
            shift_next  = {shift_reg[6:0], sda_s};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall && bitcnt_reg == BYTE_BITS) begin
            bitcnt_next  = 4'h0;
            sda_low_next = 1'b1;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == target_addr_reg) begin
                state_next = ST_ADDR_ACK;
                rw_next    = shift_reg[0];
              end else begin
                state_next   = ST_IDLE;
                sda_low_next = 1'b0;
              end
            end else if (state_reg == ST_REGA) begin
              regptr_next = shift_reg;
              state_next  = ST_REGA_ACK;
            end else begin
              wr_stb     = 1'b1;
              state_next = ST_WDAT_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bitcnt_next = 4'h0;
            if (rw_reg) begin
              rd_stb       = 1'b1;
              shift_next   = rdata;
              sda_low_next = ~rdata[7];
              state_next   = ST_RDAT;
            end else begin
              sda_low_next = 1'b0;
              state_next   = ST_REGA;
            end
          end
        end
        ST_REGA_ACK, ST_WDAT_ACK: begin
          if (scl_fall) begin
            sda_low_next = 1'b0;
            state_next   = ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_reg == BYTE_BITS) begin
              bitcnt_next  = 4'h0;
              sda_low_next = 1'b0;
              state_next   = ST_RDAT_ACK;
            end else begin
              shift_next   = {shift_reg[6:0], 1'b0};
              sda_low_next = ~shift_reg[6];
            end
          end
        end
        ST_RDAT_ACK: begin
          // a high ninth bit ends the read; low asks for the same register again
          if (scl_rise && sda_s) begin
            state_next = ST_IDLE;
          end else if (scl_fall) begin
            rd_stb       = 1'b1;
            shift_next   = rdata;
            sda_low_next = ~rdata[7];
            state_next   = ST_RDAT;
          end
        end
        default: begin
          state_next   = ST_IDLE;
          sda_low_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg   <= ST_IDLE;
      bitcnt_reg  <= 4'h0;
      shift_reg   <= 8'h00;
      regptr_reg  <= 8'h00;
      rw_reg      <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bitcnt_reg  <= bitcnt_next;
      shift_reg   <= shift_next;
      regptr_reg  <= regptr_next;
      rw_reg      <= rw_next;
      sda_low_reg <= sda_low_next;
    end
  end

  assign SDA_O      = 1'b0;
  assign SDA_OE_N_O = ~sda_low_reg;
  assign SCL_O      = 1'b0;
  assign SCL_OE_N_O = 1'b1;

  // register file
  logic [PAGE_W-1:0] page_reg;
  logic [PAGE_W-1:0] page_next;
  logic [IDX_W-1:0]  mute_reg;
  logic [IDX_W-1:0]  mute_next;
  logic [2:0]        pin_cfg_reg;
  logic [2:0]        pin_cfg_next;
  logic [INT_N-1:0]  mask_reg;
  logic [INT_N-1:0]  mask_next;
  logic [INT_N-1:0]  int_stat_reg;
  logic [INT_N-1:0]  int_stat_next;
  logic              stat_clr;

  always_comb begin
    page_next    = page_reg;
    mute_next    = mute_reg;
    pin_cfg_next = pin_cfg_reg;
    mask_next    = mask_reg;
    if (wr_stb) begin
      if (regptr_reg == REG_PAGE) begin
        page_next = shift_reg[PAGE_W-1:0];
      end else if (page_reg == PAGE_CFGIO && regptr_reg == REG_MUTE) begin
        mute_next = shift_reg[IDX_W-1:0];
      end else if (page_reg == PAGE_SHARE && regptr_reg == REG_PIN_CFG) begin
        pin_cfg_next = shift_reg[2:0];
      end else if (page_reg == PAGE_SHARE && regptr_reg == REG_INT_MASK) begin
        mask_next = shift_reg[INT_N-1:0];
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (regptr_reg == REG_PAGE) begin
      rdata = {5'h00, page_reg};
    end else if (page_reg == PAGE_CFGIO && regptr_reg == REG_MUTE) begin
      rdata = {2'h0, mute_reg};
    end else if (page_reg == PAGE_CFGIO && regptr_reg == REG_BOOST) begin
      rdata = {2'h0, boost_s};
    end else if (page_reg == PAGE_SHARE && regptr_reg == REG_PIN_CFG) begin
      rdata = {5'h00, pin_cfg_reg};
    end else if (page_reg == PAGE_SHARE && regptr_reg == REG_INT_MASK) begin
      rdata = {1'b0, mask_reg};
    end else if (page_reg == PAGE_SHARE && regptr_reg == REG_INT_STAT) begin
      rdata = {1'b0, int_stat_reg};
    end
  end

  assign stat_clr = rd_stb && page_reg == PAGE_SHARE && regptr_reg == REG_INT_STAT;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      page_reg    <= PAGE_RST;
      mute_reg    <= MUTE_RST;
      pin_cfg_reg <= PIN_CFG_RST;
      mask_reg    <= MASK_RST;
    end else begin
      page_reg    <= page_next;
      mute_reg    <= mute_next;
      pin_cfg_reg <= pin_cfg_next;
      mask_reg    <= mask_next;
    end
  end

  assign MUTE_THRESHOLD_O = mute_reg;
  assign SMBUS_SELECTED_O = smbus_en_reg;

  // interrupt events and sticky status
  logic             lock_d_reg;
  logic             coax_d_reg;
  logic             host_d_reg;
  logic             eye_d_reg;
  logic             eye_low;
  logic [INT_N-1:0] events;

  assign eye_low = heo_s | veo_s;

  always_comb begin
    events                   = '0;
    events[INT_COAX_LOS_ON]  = ~cd_mode_s & coax_d_reg & ~coax_cd_s;
    events[INT_COAX_LOS_OFF] = ~cd_mode_s & ~coax_d_reg & coax_cd_s;
    events[INT_HOST_LOS_ON]  = cd_mode_s & host_d_reg & ~host_cd_s;
    events[INT_HOST_LOS_OFF] = cd_mode_s & ~host_d_reg & host_cd_s;
    events[INT_EYE_LOW]      = lock_s & eye_low & ~eye_d_reg;
    events[INT_LOCK_GAIN]    = lock_s & ~lock_d_reg;
    events[INT_LOCK_LOSS]    = ~lock_s & lock_d_reg;
    // a new event in the clearing cycle survives the clear
    int_stat_next = (stat_clr ? '0 : int_stat_reg) | events;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lock_d_reg   <= 1'b0;
      coax_d_reg   <= 1'b0;
      host_d_reg   <= 1'b0;
      eye_d_reg    <= 1'b0;
      int_stat_reg <= STAT_RST;
    end else begin
      lock_d_reg   <= lock_s;
      coax_d_reg   <= coax_cd_s;
      host_d_reg   <= host_cd_s;
      eye_d_reg    <= eye_low;
      int_stat_reg <= int_stat_next;
    end
  end

  // shared status pin
  sbsp_pin_mode_e   pin_mode;
  logic             carrier_detect_flag;
  logic             pin_low_reg;
  logic             pin_low_next;

  assign pin_mode = sbsp_pin_mode_e'(pin_cfg_reg[PIN_MODE_LSB +: 2]);
  assign carrier_detect_flag = adapt_s & (pin_cfg_reg[PIN_SRC_BIT] ? host_cd_s : coax_cd_s);

  always_comb begin
    case (pin_mode)
      PIN_LOCK:    pin_low_next = lock_s;
      PIN_CARRIER: pin_low_next = carrier_detect_flag;
      PIN_INT:     pin_low_next = |(int_stat_reg & mask_reg);
      default:     pin_low_next = lock_s;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_low_reg <= 1'b0;
    end else begin
      pin_low_reg <= pin_low_next;
    end
  end

  assign STATUS_PIN_O      = 1'b0;
  assign STATUS_PIN_OE_N_O = ~pin_low_reg;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_addr_byte_done;
    state_reg == ST_ADDR && scl_fall && !bus_start && !bus_stop && bitcnt_reg == BYTE_BITS;
  endsequence

  a_status_od_low: assert property (STATUS_PIN_O == 1'b0 && (STATUS_PIN_OE_N_O == ~pin_low_reg))
    else $error("status pin not open drain");
  a_lock_default: assert property (pin_mode == PIN_LOCK && lock_s |=> !STATUS_PIN_OE_N_O)
    else $error("lock mode pin not low while locked");
  a_carrier_adapt: assert property (pin_mode == PIN_CARRIER && !adapt_s |=> STATUS_PIN_OE_N_O)
    else $error("carrier pin low before adaptation done");
  a_carrier_src: assert property (pin_mode == PIN_CARRIER && adapt_s && pin_cfg_reg[PIN_SRC_BIT]
                                  && host_cd_s |=> !STATUS_PIN_OE_N_O)
    else $error("host carrier source not shown");
  a_int_pin_mask: assert property (pin_mode == PIN_INT && (int_stat_reg & mask_reg) == '0
                                   |=> STATUS_PIN_OE_N_O)
    else $error("interrupt pin low with no masked event");
  a_los_coax: assert property (!cd_mode_s && coax_d_reg && !coax_cd_s
                               |=> int_stat_reg[INT_COAX_LOS_ON])
    else $error("coax loss of signal not flagged");
  a_eye_flag: assert property (lock_s && eye_low && !eye_d_reg |=> int_stat_reg[INT_EYE_LOW])
    else $error("eye low event not flagged");
  a_lock_flag: assert property ($fell(lock_s) |=> int_stat_reg[INT_LOCK_LOSS])
    else $error("lock loss not flagged");
  a_sticky_hold: assert property (!stat_clr |=> (int_stat_reg & $past(int_stat_reg)) == $past(int_stat_reg))
    else $error("interrupt flag dropped without read");
  a_mute_write: assert property (wr_stb && page_reg == PAGE_CFGIO && regptr_reg == REG_MUTE
                                 |=> MUTE_THRESHOLD_O == $past(shift_reg[IDX_W-1:0]))
    else $error("mute threshold write lost");
  a_spi_silent: assert property (strap_done_reg && !smbus_en_reg |-> SDA_OE_N_O)
    else $error("bus driven outside smbus mode");
  a_addr_range: assert property (strap_done_reg |-> target_addr_reg >= 7'h2D && target_addr_reg <= 7'h3C)
    else $error("target address out of range");
  a_ack_hold: assert property ((state_reg == ST_ADDR_ACK || state_reg == ST_REGA_ACK
                                || state_reg == ST_WDAT_ACK) |-> !SDA_OE_N_O)
    else $error("acknowledge not held low");
  a_addr_match: assert property (s_addr_byte_done ##0 (shift_reg[7:1] == target_addr_reg)
                                 |=> state_reg == ST_ADDR_ACK ##0 !SDA_OE_N_O)
    else $error("matching address not acknowledged");
  a_addr_ignore: assert property (s_addr_byte_done ##0 (shift_reg[7:1] != target_addr_reg)
                                  |=> state_reg == ST_IDLE ##0 SDA_OE_N_O)
    else $error("foreign address acknowledged");
  a_bus_od: assert property (SDA_O == 1'b0 && SCL_O == 1'b0 && SCL_OE_N_O)
    else $error("bus pin driven high");
  a_page_write: assert property (wr_stb && regptr_reg == REG_PAGE
                                 |=> page_reg == $past(shift_reg[PAGE_W-1:0]))
    else $error("page select write lost");
  a_stop_idle: assert property (bus_stop |=> state_reg == ST_IDLE && SDA_OE_N_O)
    else $error("stop did not release the bus");
  a_read_nack: assert property (state_reg == ST_RDAT_ACK && scl_rise && sda_s && !bus_start && !bus_stop
                                |=> state_reg == ST_IDLE)
    else $error("read not ended by not-acknowledge");
endmodule : sbsp_top

//--- sbsp_pkg.sv
// package with shared constants and types for the smbus target and status pin block
// assumes a 125 MHz system clock and a four-level pin decoder in front of every strap
package sbsp_pkg;

  // clock and bus rates
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int SCL_MAX_KHZ  = 400;

  // data widths
  localparam int IDX_W  = 6;
  localparam int INT_N  = 7;
  localparam int PAGE_W = 3;

  // register offsets
  localparam logic [7:0] REG_MUTE     = 8'h03;
  localparam logic [7:0] REG_BOOST    = 8'h25;
  localparam logic [7:0] REG_PIN_CFG  = 8'h40;
  localparam logic [7:0] REG_INT_MASK = 8'h41;
  localparam logic [7:0] REG_INT_STAT = 8'h42;
  localparam logic [7:0] REG_PAGE     = 8'hFF;

  // register pages
  localparam logic [PAGE_W-1:0] PAGE_SHARE = 3'h0;
  localparam logic [PAGE_W-1:0] PAGE_CFGIO = 3'h5;

  // pin configuration fields
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_SRC_BIT  = 2;

  // values after reset
  localparam logic [PAGE_W-1:0] PAGE_RST    = 3'h0;
  localparam logic [IDX_W-1:0]  MUTE_RST    = 6'h00;
  localparam logic [2:0]        PIN_CFG_RST = 3'h0;
  localparam logic [INT_N-1:0]  MASK_RST    = 7'h00;
  localparam logic [INT_N-1:0]  STAT_RST    = 7'h00;

  // interrupt status bit positions
  localparam int INT_COAX_LOS_ON  = 0;
  localparam int INT_COAX_LOS_OFF = 1;
  localparam int INT_HOST_LOS_ON  = 2;
  localparam int INT_HOST_LOS_OFF = 3;
  localparam int INT_EYE_LOW      = 4;
  localparam int INT_LOCK_GAIN    = 5;
  localparam int INT_LOCK_LOSS    = 6;

  // target address and strap handling
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h2D;
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;
  localparam logic [3:0] BYTE_BITS        = 4'h8;

  // four-level pin codes, ordered low, resistor, float, high
  typedef enum logic [1:0] {
    LVL_L = 2'b00,
    LVL_R = 2'b01,
    LVL_F = 2'b10,
    LVL_H = 2'b11
  } sbsp_level_e;

  typedef enum logic [1:0] {
    PIN_LOCK    = 2'b00,
    PIN_CARRIER = 2'b01,
    PIN_INT     = 2'b10
  } sbsp_pin_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_REGA     = 4'b0011,
    ST_REGA_ACK = 4'b0100,
    ST_WDAT     = 4'b0101,
    ST_WDAT_ACK = 4'b0110,
    ST_RDAT     = 4'b0111,
    ST_RDAT_ACK = 4'b1000
  } sbsp_state_e;

endpackage : sbsp_pkg

//--- sbsp_sync.sv
// two flip-flop synchroniser for a vector of quasi-static or slow inputs
// assumes each bit is sampled on its own; multi-bit values must be stable around a read
`timescale 1ns/1ns
module sbsp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= d_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign q_o = stage2_reg;
endmodule : sbsp_sync

//--- sbsp_top_fix_note_unused.sv
// holds no logic; the block itself lives in sbsp_top.sv

//--- sbsp_ctrl.sv
// smbus controller model: open-drain clock and data, 160 ns bus clock
// assumes the bench ands its lines with the target's enables and pull-ups
`timescale 1ns/1ns
module sbsp_ctrl (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic r;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // data set while clock low, held across the whole high phase
  task automatic clk_bit(input logic b);
    sda_o = b;
    #40 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
    #40;
  endtask : clk_bit
  task automatic start;
    sda_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b0;
    #40;
  endtask : start
  task automatic stop;
    sda_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_o = 1'b1;
    #80;
  endtask : stop
  // msb first, ninth clock carries the receiver's answer
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i]);
      q[i] = r;
    end
    clk_bit(a);
    k = r;
  endtask : xfer
endmodule : sbsp_ctrl

//--- sbsp_top_bench.sv
// self-checking bench for the smbus target and status pin block
// assumes sbsp_ctrl as bus controller and pull-ups on every open-drain wire
`timescale 1ns/1ns
module sbsp_top_bench;
  import sbsp_pkg::*;
  logic       clk_i, rst_n_i, lock, eye, cs, cd, scl_oe_n, sda_oe_n, sel, st_oe_n, k;
  logic       coax, host, adapt, cdm;
  logic [1:0] maj, mnr, ms;
  logic [5:0] boost, mute;
  logic [6:0] addr;
  logic [7:0] q;
  int         n_errors, n_tests, seed, mdl_mute;
  wire        scl = cs & scl_oe_n;
  wire        sda = cd & sda_oe_n;
  sbsp_ctrl c (.sda_i(sda), .scl_o(cs), .sda_o(cd));
  sbsp_top uut (.CLK_I(clk_i), .RST_N_I(rst_n_i), .SCL_I(scl), .SCL_O(), .SCL_OE_N_O(scl_oe_n),
    .SDA_I(sda), .SDA_O(), .SDA_OE_N_O(sda_oe_n), .MODE_SELECT_I(ms),
    .ADDRESS_STRAP_MAJOR_I(maj), .ADDRESS_STRAP_MINOR_I(mnr), .RECLOCK_LOCK_I(lock),
    .BIDIR_COAX_PORT_CD_I(coax), .HOST_DIFF_INPUT_CD_I(host), .ADAPT_DONE_I(adapt),
    .CABLE_DRIVER_MODE_I(cdm), .HORIZONTAL_EYE_OPENING_LOW_I(eye),
    .VERTICAL_EYE_OPENING_LOW_I(eye), .CABLE_EQ_BOOST_INDEX_I(boost),
    .MUTE_THRESHOLD_O(mute), .SMBUS_SELECTED_O(sel), .STATUS_PIN_O(), .STATUS_PIN_OE_N_O(st_oe_n));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [7:0] z;
    logic       k0, k1, k2;
    c.start();
    c.xfer({addr, 1'b0}, 1'b1, z, k0);
    c.xfer(ra, 1'b1, z, k1);
    c.xfer(d, 1'b1, z, k2);
    c.stop();
    if (ra == REG_MUTE) mdl_mute = d[5:0];
    chk({5'h0, k0, k1, k2}, 8'h00, "write ack");
  endtask : wr
  task automatic rd(input logic [7:0] ra, output logic [7:0] d);
    logic [7:0] z;
    logic       k0, k1, k2, k3;
    c.start();
    c.xfer({addr, 1'b0}, 1'b1, z, k0);
    c.xfer(ra, 1'b1, z, k1);
    c.start();
    c.xfer({addr, 1'b1}, 1'b1, z, k2);
    c.xfer(8'hFF, 1'b1, d, k3);
    c.stop();
    chk({5'h0, k0, k1, k2}, 8'h00, "read ack");
  endtask : rd
  task automatic wrap_up;
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    #400_000;
    n_errors++;
    wrap_up();
  end
  initial begin
    seed = 32'h08e5;
    {maj, mnr} = 4'($random(seed));
    boost = 6'($unsigned($random(seed)) % 56);
    {lock, eye, rst_n_i, coax, host, adapt, cdm} = 7'b1001110;
    ms = LVL_L;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (12) @(negedge clk_i);
    chk({6'h0, sel, st_oe_n}, 8'h02, "select and lock pin");
    addr = 7'h2D + {3'h0, maj, 2'h0} + {5'h0, mnr};
    c.start();
    c.xfer({addr ^ 7'h01, 1'b0}, 1'b1, q, k);
    c.stop();
    chk({7'h0, k}, 8'h01, "foreign address");
    wr(REG_PAGE, {5'h0, PAGE_CFGIO});
    wr(REG_MUTE, 8'($random(seed)) & 8'h3F);
    chk({2'h0, mute}, 8'(mdl_mute), "mute pin");
    rd(REG_MUTE, q);
    chk(q, 8'(mdl_mute), "mute read");
    rd(REG_BOOST, q);
    chk(q, {2'h0, boost}, "boost read");
    wr(REG_MUTE, q);
    chk({2'h0, mute}, {2'h0, boost}, "calibrated mute");
    rd(8'h77, q);
    chk(q, 8'h00, "unmapped read");
    wr(REG_PAGE, 8'h00);
    wr(REG_PIN_CFG, 8'h02);
    wr(REG_INT_MASK, 8'h40);
    rd(REG_INT_STAT, q);
    lock = 1'b0;
    repeat (6) @(negedge clk_i);
    lock = 1'b1;
    repeat (6) @(negedge clk_i);
    chk({7'h0, st_oe_n}, 8'h00, "interrupt pin held");
    rd(REG_INT_STAT, q);
    chk(q, 8'h60, "interrupt status");
    chk({7'h0, st_oe_n}, 8'h01, "interrupt pin released");
    wr(REG_INT_MASK, 8'h1F);
    {coax, eye} = 2'b01;
    repeat (6) @(negedge clk_i);
    chk({7'h0, st_oe_n}, 8'h00, "loss and eye pin");
    rd(REG_INT_STAT, q);
    chk(q, 8'h11, "loss and eye status");
    coax = 1'b1;
    repeat (6) @(negedge clk_i);
    cdm = 1'b1;
    repeat (6) @(negedge clk_i);
    host = 1'b0;
    repeat (6) @(negedge clk_i);
    host = 1'b1;
    repeat (6) @(negedge clk_i);
    rd(REG_INT_STAT, q);
    chk(q, 8'h0E, "loss end and host status");
    wr(REG_PIN_CFG, 8'h01);
    adapt = 1'b0;
    repeat (6) @(negedge clk_i);
    chk({7'h0, st_oe_n}, 8'h01, "carrier before adaptation");
    adapt = 1'b1;
    repeat (6) @(negedge clk_i);
    chk({7'h0, st_oe_n}, 8'h00, "coax carrier");
    host = 1'b0;
    wr(REG_PIN_CFG, 8'h05);
    chk({7'h0, st_oe_n}, 8'h01, "host carrier lost");
    ms = LVL_F;
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (12) @(negedge clk_i);
    chk({sel, st_oe_n, mute}, 8'h00, "spi select after reset");
    c.start();
    c.xfer({addr, 1'b0}, 1'b1, q, k);
    c.stop();
    chk({7'h0, k}, 8'h01, "smbus off in spi mode");
    wrap_up();
  end
endmodule : sbsp_top_bench
